/* coax_transceiver_control.sv */
// squelch, jabber, heartbeat and collision control of a coax transceiver
module coax_transceiver_control #(
    parameter int unsigned JAB_TICKS   = coax_pkg::JAB_TICKS_DEF,
    parameter int unsigned UNJAB_TICKS = coax_pkg::UNJAB_TICKS_DEF
) (
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire coax_pkg::line_flags_t line_flags,
    input  wire logic                  rx_ready,
    output logic                       rx_valid,
    output logic                       rx_in_ready,
    output logic [1:0]                 rx_out_pair,
    output logic [1:0]                 collision_out_pair,
    output logic                       coax_drive_output,
    output logic                       coax_drive_en,
    output logic                       jabber_fault
);
    import coax_pkg::*;

    // --------------------------------------------------------------
    // parameter checks
    // --------------------------------------------------------------
    if (JAB_TICKS < 1 || JAB_TICKS >= (1 << JCW) ||
        UNJAB_TICKS < 1 || UNJAB_TICKS >= (1 << JCW)) begin : g_chk
        $error("jabber tick counts do not fit the counter");
    end

    localparam logic [JCW-1:0] JAB_END   = JCW'(JAB_TICKS);
    localparam logic [JCW-1:0] UNJAB_END = JCW'(UNJAB_TICKS);

    // all state of the block
    typedef struct packed {
        line_flags_t    s1;      // sync stage one, read by s2 only
        line_flags_t    s2;      // synchronised flags
        logic [4:0]     acc;     // oscillator phase accumulator
        logic           osc;     // 10 MHz square wave
        logic           tick;    // one cycle per oscillator period
        rx_state_t      rx_st;   // receive squelch state
        logic [7:0]     rx_cnt;  // receive squelch timer
        tx_state_t      tx_st;   // transmit / jabber state
        logic [5:0]     tx_cnt;  // transmit squelch timer
        logic [JCW-1:0] jab_cnt; // jabber and unjab ticks
        hb_state_t      hb_st;   // heartbeat state
        logic [3:0]     hb_cnt;  // heartbeat ticks
        logic [1:0]     b_cnt;   // buffer fill
        logic           b0;      // head entry
        logic           b1;      // second entry
        logic           in_rdy;  // buffer can take a bit
        logic           vld;     // head entry valid
        logic [1:0]     rxp;     // receive pair drive
        logic [1:0]     cdp;     // collision pair drive
        logic           drv;     // coax drive data
        logic           drv_en;  // coax driver on
        logic           jab;     // jabber fault flag
    } state_t;

    state_t q;                   // registered state
    state_t d;                   // next state

    // --------------------------------------------------------------
    // next-state logic
    // --------------------------------------------------------------
    // one process so every field sees the same q snapshot
    always_comb begin
        logic [1:0] n;           // buffer fill after pop and push
        logic       act;         // collision pair condition
        logic       hb_go;       // normal end asks for a heartbeat
        n = 2'b00;
        act = 1'b0;
        hb_go = 1'b0;
        d = q;
        d.s1 = line_flags;
        d.s2 = q.s1;

        // fractional divider: 20 MHz toggles from 125 MHz
        d.tick = 1'b0;
        if (q.acc >= 5'(OSC_MOD - OSC_STEP)) begin
            d.acc  = 5'(q.acc + OSC_STEP - OSC_MOD);
            d.osc  = ~q.osc;
            d.tick = ~q.osc;
        end else begin
            d.acc = 5'(q.acc + OSC_STEP);
        end

        // receive squelch
        unique case (q.rx_st)
            RX_OFF: begin
                d.rx_cnt = 8'h00;
                if (q.s2.rx_dc_below) begin
                    d.rx_st = RX_ON;
                end
            end
            RX_ON: begin
                if (!q.s2.rx_dc_below) begin
                    d.rx_st  = RX_OFF;
                end else if (!q.s2.rx_high) begin
                    d.rx_cnt = 8'h00;
                end else if (q.rx_cnt == RX_HIGH_CYC) begin
                    // level longer than the limit: dribble bits
                    d.rx_st  = RX_QUICK;
                    d.rx_cnt = 8'h00;
                end else begin
                    d.rx_cnt = 8'(q.rx_cnt + 8'h01);
                end
            end
            RX_QUICK: begin
                d.rx_cnt = 8'(q.rx_cnt + 8'h01);
                if (!q.s2.rx_dc_below) begin
                    d.rx_st = RX_OFF;
                end else if (q.rx_cnt == RX_REC_CYC) begin
                    d.rx_st  = RX_ON;
                    d.rx_cnt = 8'h00;
                end
            end
        endcase

        // transmit squelch, jabber and unjab
        unique case (q.tx_st)
            TX_IDLE: begin
                if (!q.s2.tx_active) begin
                    d.tx_cnt = 6'h00;
                end else if (q.tx_cnt == 6'(TX_GLITCH_CYC - 1)) begin
                    // wide enough pulse: start and arm jabber
                    d.tx_st   = TX_ON;
                    d.tx_cnt  = 6'h00;
                    d.jab_cnt = '0;
                end else begin
                    d.tx_cnt = 6'(q.tx_cnt + 6'h01);
                end
            end
            TX_ON: begin
                d.jab_cnt = JCW'(q.jab_cnt + JCW'(q.tick));
                d.tx_cnt  = q.s2.tx_active ? 6'h00 :
                            6'(q.tx_cnt + 6'h01);
                if (q.jab_cnt == JAB_END) begin
                    d.tx_st  = TX_JAB;
                    d.tx_cnt = 6'h00;
                end else if (q.tx_cnt == TX_END_CYC &&
                             !q.s2.tx_active) begin
                    d.tx_st  = TX_IDLE;
                    d.tx_cnt = 6'h00;
                    // pin high means strapped to ground
                    hb_go = q.s2.heartbeat_enable_pin;
                end
            end
            TX_JAB: begin
                // fault holds until the input goes quiet
                d.tx_cnt = q.s2.tx_active ? 6'h00 :
                           6'(q.tx_cnt + 6'h01);
                if (q.tx_cnt == TX_END_CYC && !q.s2.tx_active) begin
                    d.tx_st   = TX_UNJAB;
                    d.jab_cnt = '0;
                end
            end
            TX_UNJAB: begin
                // input activity here is ignored, not restarted
                d.jab_cnt = JCW'(q.jab_cnt + JCW'(q.tick));
                if (q.jab_cnt == UNJAB_END) begin
                    d.tx_st  = TX_IDLE;
                    d.tx_cnt = 6'h00;
                end
            end
            default: d.tx_st = TX_IDLE;
        endcase

        // heartbeat timing in timebase ticks
        unique case (q.hb_st)
            HB_IDLE: ;
            HB_WAIT: begin
                d.hb_cnt = 4'(q.hb_cnt + 4'(q.tick));
                if (q.hb_cnt == HB_DLY_TICKS) begin
                    d.hb_st  = HB_BURST;
                    d.hb_cnt = 4'h0;
                end
            end
            HB_BURST: begin
                d.hb_cnt = 4'(q.hb_cnt + 4'(q.tick));
                if (q.hb_cnt == HB_LEN_TICKS) begin
                    d.hb_st = HB_IDLE;
                end
            end
            default: d.hb_st = HB_IDLE;
        endcase
        // a new end restarts the wait; set wins over a burst ending
        if (hb_go) begin
            d.hb_st  = HB_WAIT;
            d.hb_cnt = 4'h0;
        end

        // two-entry buffer: receiver bits toward the station
        n = q.b_cnt;
        if (q.vld && rx_ready) begin
            d.b0 = q.b1;
            n    = 2'(n - 2'd1);
        end
        if (q.rx_st == RX_ON && q.in_rdy) begin
            if (n == 2'd0) begin
                d.b0 = q.s2.coax_receive_input;
            end else begin
                d.b1 = q.s2.coax_receive_input;
            end
            n = 2'(n + 2'd1);
        end
        d.b_cnt  = n;
        d.in_rdy = (n != 2'd2);
        d.vld    = (n != 2'd0);
        // idle pair at zero differential
        d.rxp = d.vld ? {d.b0, ~d.b0} : 2'b00;

        // collision pair gating
        act = q.s2.coll_cmp || q.tx_st == TX_JAB ||
              q.hb_st == HB_BURST;
        // zero differential when no condition holds
        d.cdp = act ? {d.osc, ~d.osc} : 2'b00;
        d.drv_en = (q.tx_st == TX_ON);
        d.drv    = (q.tx_st == TX_ON) && q.s2.tx_data;
        d.jab    = (q.tx_st == TX_JAB);
    end

    // state register; constants only under reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '{rx_st: RX_OFF, tx_st: TX_IDLE, hb_st: HB_IDLE,
                   in_rdy: 1'b1, default: '0};
        end else begin
            q <= d;
        end
    end

    assign rx_valid           = q.vld;
    assign rx_in_ready        = q.in_rdy;
    assign rx_out_pair        = q.rxp;
    assign collision_out_pair = q.cdp;
    assign coax_drive_output  = q.drv;
    assign coax_drive_en      = q.drv_en;
    assign jabber_fault       = q.jab;

    // --------------------------------------------------------------
    // assertions
    // --------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    rx_turn_on_a: assert property (
        q.rx_st == RX_OFF && q.s2.rx_dc_below |=> q.rx_st == RX_ON)
        else $error("receiver did not turn on");
    rx_quick_off_a: assert property (
        $rose(q.rx_st == RX_QUICK) |->
        $past(q.s2.rx_high) && $past(q.rx_cnt) == RX_HIGH_CYC)
        else $error("quick turn-off without long high level");
    rx_resume_a: assert property (
        q.rx_st == RX_QUICK && !q.s2.rx_dc_below |=> q.rx_st == RX_OFF)
        else $error("receiver not held off after dc rise");
    rx_idle_zero_a: assert property (
        !rx_valid |-> rx_out_pair == 2'b00)
        else $error("receive pair not at zero when idle");
    tx_glitch_a: assert property (
        $rose(q.tx_st == TX_ON) |-> $past(q.s2.tx_active, 1) &&
        $past(q.s2.tx_active, 2) && $past(q.s2.tx_active, 3))
        else $error("transmit started on a narrow pulse");
    tx_end_a: assert property (
        $fell(q.tx_st == TX_ON) && q.tx_st == TX_IDLE |->
        !$past(q.s2.tx_active))
        else $error("transmit ended while input active");
    cd_gate_a: assert property (
        q.s2.coll_cmp |=> collision_out_pair != 2'b00)
        else $error("collision pair idle during collision");
    cd_idle_a: assert property (
        collision_out_pair != 2'b00 |-> $past(q.s2.coll_cmp ||
        q.tx_st == TX_JAB || q.hb_st == HB_BURST))
        else $error("collision pair driven with no condition");
    jab_inhibit_a: assert property (
        jabber_fault |-> !coax_drive_en)
        else $error("transmit not inhibited in jabber");
    hb_strap_a: assert property (
        $fell(q.tx_st == TX_ON) && q.tx_st == TX_IDLE &&
        !$past(q.s2.heartbeat_enable_pin) &&
        $past(q.hb_st) == HB_IDLE |-> q.hb_st == HB_IDLE)
        else $error("heartbeat started while disabled");

    quick_resume_c: cover property (q.rx_st == RX_QUICK ##1
        q.rx_st == RX_ON);
    heartbeat_c: cover property ($rose(q.hb_st == HB_BURST));
    jabber_c: cover property ($rose(q.tx_st == TX_JAB));
endmodule // coax_transceiver_control

/* coax_pkg.sv */
// constants and carrier types for the coax transceiver control block
package coax_pkg;
    // --------------------------------------------------------------
    // clock and on-chip timebase
    // --------------------------------------------------------------
    localparam int unsigned CLK_MHZ  = 125;  // system clock rate
    localparam int unsigned CLK_NS   = 8;    // system clock period
    localparam int unsigned OSC_MHZ  = 10;   // collision signal rate
    // osc toggles at twice its rate: step/modulus = 20 / 125
    localparam logic [4:0]  OSC_STEP = 5'(2 * OSC_MHZ / 5);
    localparam logic [4:0]  OSC_MOD  = 5'(CLK_MHZ / 5);
    localparam int unsigned TICK_NS  = 1000 / OSC_MHZ;

    // --------------------------------------------------------------
    // squelch times, counted in clock cycles
    // --------------------------------------------------------------
    localparam int unsigned RX_HIGH_NS = 200;   // quick turn-off level
    localparam logic [7:0]  RX_HIGH_CYC =
        8'((RX_HIGH_NS + CLK_NS - 1) / CLK_NS);
    localparam int unsigned RX_REC_NS = 1000;   // dc rise window
    localparam logic [7:0]  RX_REC_CYC = 8'(RX_REC_NS / CLK_NS);
    localparam int unsigned TX_GLITCH_NS = 20;  // least start pulse
    localparam logic [5:0]  TX_GLITCH_CYC =
        6'((TX_GLITCH_NS + CLK_NS - 1) / CLK_NS);
    localparam int unsigned TX_END_NS = 300;    // end-of-packet idle
    localparam logic [5:0]  TX_END_CYC =
        6'((TX_END_NS + CLK_NS - 1) / CLK_NS);

    // --------------------------------------------------------------
    // heartbeat and jabber times, counted in timebase ticks
    // --------------------------------------------------------------
    localparam int unsigned HB_DLY_NS = 1100;
    localparam logic [3:0]  HB_DLY_TICKS = 4'(HB_DLY_NS / TICK_NS);
    localparam int unsigned HB_LEN_NS = 1000;
    localparam logic [3:0]  HB_LEN_TICKS = 4'(HB_LEN_NS / TICK_NS);
    localparam int unsigned JAB_MS   = 20;
    localparam int unsigned JAB_TICKS_DEF = JAB_MS * 1000000 / TICK_NS;
    localparam int unsigned UNJAB_MS = 500;
    localparam int unsigned UNJAB_TICKS_DEF =
        UNJAB_MS * 1000000 / TICK_NS;
    localparam int unsigned JCW = 23;          // jabber counter width

    // --------------------------------------------------------------
    // carrier and state types
    // --------------------------------------------------------------
    typedef struct packed {
        logic rx_dc_below;          // filtered dc under squelch level
        logic rx_high;              // coax at high level
        logic coax_receive_input;   // sliced receive data
        logic tx_active;            // transmit input under -175 mV
        logic tx_data;              // transmit data
        logic coll_cmp;             // data under sense by threshold
        logic heartbeat_enable_pin; // 1 = pin grounded
    } line_flags_t;

    typedef enum logic [1:0] {RX_OFF, RX_ON, RX_QUICK} rx_state_t;
    typedef enum logic [2:0] {TX_IDLE, TX_ON, TX_JAB, TX_UNJAB}
        tx_state_t;
    typedef enum logic [1:0] {HB_IDLE, HB_WAIT, HB_BURST} hb_state_t;
endpackage : coax_pkg

/* station_model.sv */
// station-side model: drains the receive pair, sends transmit packets
module station_model (
    input  wire logic       clk,
    input  wire logic       stall,
    input  wire logic       rx_valid,
    input  wire logic [1:0] rx_out_pair,
    output logic            rx_ready,
    output logic            tx_active,
    output logic            tx_data
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // receive side
    // ------------------------------------------------------------
    int rx_count = 0;   // bits taken off the pair

    // idle transmit lines start quiet
    initial begin
        tx_active = 1'b0;
        tx_data   = 1'b0;
    end
    // ready follows stall, which the bench moves on the falling edge;
    // a copy sampled on that same edge would race the bench
    assign rx_ready = !stall;
    // a bit is taken at each rising edge with valid and ready
    always @(posedge clk) begin
        if (rx_valid && rx_ready) begin
            rx_count <= rx_count + 1;
        end
    end
    // ------------------------------------------------------------
    // transmit side
    // ------------------------------------------------------------
    // one packet of n cycles carrying bit d; callers keep the
    // input quiet through any unjab wait
    task automatic send(input int n, input logic d);
        @(negedge clk);
        tx_active = 1'b1;
        tx_data   = d;
        repeat (n) @(negedge clk);
        tx_active = 1'b0;
        tx_data   = ~d;  // released: no stale level left behind
    endtask
endmodule // station_model

/* tb_top.sv */
// self-checking bench for the coax transceiver control block
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import coax_pkg::*;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    localparam int unsigned JT = 20;  // short jabber limit, ticks
    localparam int unsigned UT = 30;  // short unjab wait, ticks
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        dc_below = 1'b0;
    logic        rx_high = 1'b0;
    logic        rx_bit = 1'b1;
    logic        coll = 1'b0;
    logic        hb_pin = 1'b1;
    logic        stall = 1'b0;
    logic        tx_act, tx_dat, rx_ready, rx_valid, rx_in_ready;
    logic        drive, drive_en, jab;
    logic [1:0]  rx_out_pair, col;
    line_flags_t flags;
    int          failures = 0;
    int          checks = 0;

    always #4 clk = ~clk;  // 125 MHz
    assign flags = {dc_below, rx_high, rx_bit, tx_act, tx_dat, coll,
                    hb_pin};

    coax_transceiver_control #(.JAB_TICKS(JT), .UNJAB_TICKS(UT)) uut (
        .clk(clk), .rst_n(rst_n), .line_flags(flags),
        .rx_ready(rx_ready), .rx_valid(rx_valid),
        .rx_in_ready(rx_in_ready), .rx_out_pair(rx_out_pair),
        .collision_out_pair(col), .coax_drive_output(drive),
        .coax_drive_en(drive_en), .jabber_fault(jab));
    station_model peer (
        .clk(clk), .stall(stall), .rx_valid(rx_valid),
        .rx_out_pair(rx_out_pair), .rx_ready(rx_ready),
        .tx_active(tx_act), .tx_data(tx_dat));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic chk1(input string n, input logic e, input logic g);
        checks++;
        if (g !== e) begin
            failures++;
            $display("mismatch %s expected %b seen %b", n, e, g);
        end
    endtask
    task automatic chk2(input string n, input logic [1:0] e,
                        input logic [1:0] g);
        checks++;
        if (g !== e) begin
            failures++;
            $display("mismatch %s expected %b seen %b", n, e, g);
        end
    endtask
    // watch the collision pair: first/last active cycle, phases, edges
    task automatic scan(input int n, output int f, output int l,
                        output logic [1:0] ph, output int ed);
        logic [1:0] prev;
        f = -1;
        l = -1;
        ph = 2'b00;
        ed = 0;
        prev = col;
        for (int i = 0; i < n; i++) begin
            cyc(1);
            if (col !== 2'b00) begin
                if (f < 0) f = i;
                l = i;
                ph |= {col === 2'b10, col === 2'b01};
            end
            if (col !== prev) ed++;
            prev = col;
        end
    endtask
    task automatic complete_run;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    // outputs idle at zero differential while held in reset
    task automatic t_reset;
        chk2("rx_out_pair", 2'b00, rx_out_pair);
        chk2("collision_pair", 2'b00, col);
        chk1("rx_in_ready", 1'b1, rx_in_ready);
        chk1("drive_en", 1'b0, drive_en);
    endtask
    // squelch on, buffer fill under stall, quick off and recovery
    task automatic t_rx;
        dc_below = 1'b1;
        for (int i = 0; i < 10 && rx_valid !== 1'b1; i++) cyc(1);
        chk1("rx_valid", 1'b1, rx_valid);
        chk2("rx_out_pair", 2'b10, rx_out_pair);
        stall = 1'b1;
        cyc(6);
        chk1("rx_in_ready", 1'b0, rx_in_ready);
        chk2("rx_out_pair", 2'b10, rx_out_pair);
        stall = 1'b0;
        rx_high = 1'b1;
        cyc(20);
        chk1("rx_valid", 1'b1, rx_valid);
        chk1("rx_taken", 1'b1, peer.rx_count > 0);
        cyc(20);
        chk1("rx_valid", 1'b0, rx_valid);
        rx_high = 1'b0;
        cyc(60);
        chk1("rx_valid", 1'b0, rx_valid);
        cyc(70);
        chk1("rx_valid", 1'b1, rx_valid);
        rx_high = 1'b1;
        cyc(40);
        rx_high = 1'b0;
        dc_below = 1'b0;
        cyc(200);
        chk1("rx_valid", 1'b0, rx_valid);
        chk2("rx_out_pair", 2'b00, rx_out_pair);
    endtask
    // a two-cycle pulse never starts the transmitter
    task automatic t_glitch;
        logic seen;
        seen = 1'b0;
        fork
            peer.send(2, 1'b1);
            for (int i = 0; i < 25; i++) begin
                cyc(1);
                seen |= drive_en;
            end
        join
        chk1("drive_en", 1'b0, seen);
    endtask
    // normal packet, end by idle input, heartbeat per pin strap
    task automatic t_tx(input logic pin);
        int f, l, ed;
        logic [1:0] ph;
        hb_pin = pin;
        fork
            peer.send(60, 1'b1);
            begin
                cyc(12);
                chk1("drive_en", 1'b1, drive_en);
                chk1("drive", 1'b1, drive);
            end
        join
        cyc(20);
        chk1("drive_en", 1'b1, drive_en);
        cyc(30);
        chk1("drive_en", 1'b0, drive_en);
        chk1("drive", 1'b0, drive);
        scan(300, f, l, ph, ed);
        if (pin) begin
            chk1("hb_start", 1'b1, f >= 90 && f <= 160);
            chk1("hb_len", 1'b1, l - f >= 110 && l - f <= 140);
            chk2("hb_phases", 2'b11, ph);
        end else begin
            chk1("hb_off", 1'b1, f < 0);
        end
        chk2("collision_pair", 2'b00, col);
    endtask
    // comparator flag gates a 10 MHz square onto the pair
    task automatic t_coll;
        int f, l, ed;
        logic [1:0] ph;
        coll = 1'b1;
        scan(100, f, l, ph, ed);
        chk1("coll_start", 1'b1, f >= 0 && f <= 6);
        chk1("coll_held", 1'b1, l == 99);
        chk1("osc_rate", 1'b1, ed >= 15 && ed <= 18);
        coll = 1'b0;
        cyc(6);
        chk2("collision_pair", 2'b00, col);
    endtask
    // overlong packet trips jabber, unjab wait, then a clean packet
    task automatic t_jab;
        int f, l, ed;
        logic [1:0] ph;
        hb_pin = 1'b0;
        fork
            peer.send(500, 1'b1);
            begin
                cyc(200);
                chk1("drive_en", 1'b1, drive_en);
                cyc(100);
                chk1("jabber_fault", 1'b1, jab);
                chk1("drive_en", 1'b0, drive_en);
                scan(100, f, l, ph, ed);
                chk2("jab_phases", 2'b11, ph);
            end
        join
        cyc(60);
        chk1("jabber_fault", 1'b0, jab);
        cyc(450);
        fork
            peer.send(60, 1'b0);
            begin
                cyc(12);
                chk1("drive_en", 1'b1, drive_en);
                chk1("drive", 1'b0, drive);
            end
        join
        chk1("jabber_fault", 1'b0, jab);
    endtask
    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        cyc(11);
        t_reset;
        cyc(1);
        rst_n = 1'b1;
        cyc(4);
        t_rx;
        t_glitch;
        t_tx(1'b1);
        t_tx(1'b0);
        t_coll;
        t_jab;
        complete_run;
    end
    // tests need about 2500 cycles; allow several times that
    initial begin
        #200000;
        failures++;
        $display("mismatch watchdog expected done seen hang");
        complete_run;
    end
endmodule // tb_top
